/* src/aao_pkg.sv */
/*
  aao_pkg: constants, types and register layout shared by the 8-bit
  arithmetic/logic datapath and its adder/logic slice.
  assumes: a 32-bit apb bus with byte addresses held in 8 bits.
*/
package aao_pkg;

  // --------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPA = 8'h04;
  localparam logic [7:0] ADDR_OPB = 8'h08;
  localparam logic [7:0] ADDR_OPH = 8'h0c;
  localparam logic [7:0] ADDR_RES = 8'h10;
  localparam logic [7:0] ADDR_SREG = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  // i/o window: index i sits at IO_BASE + 4*i
  localparam logic [7:0] IO_BASE = 8'h80;
  localparam logic [7:0] IO_WIN_MASK = 8'h80;
  localparam int unsigned IO_N = 32;
  localparam logic [7:0] IO_TOP_ADDR = 8'h1f;

  // i/o register holding flags that clear on a written one
  localparam logic [4:0] IO_FLAG_IDX = 5'h0b;
  localparam logic [7:0] IO_FLAG_MASK = 8'he0;

  // status register bits
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_RANGE = 1;

  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // --------------------------------------------------------------------
  // operation codes written into the command field
  // --------------------------------------------------------------------
  localparam logic [4:0] OP_SUM = 5'h00;
  localparam logic [4:0] OP_SUM_CARRY = 5'h01;
  localparam logic [4:0] OP_WORD_IMMEDIATE_SUM = 5'h02;
  localparam logic [4:0] OP_DIFFERENCE = 5'h03;
  localparam logic [4:0] OP_DIFFERENCE_CONSTANT = 5'h04;
  localparam logic [4:0] OP_DIFFERENCE_WITH_BORROW = 5'h05;
  localparam logic [4:0] OP_DIFFERENCE_CONSTANT_BORROW = 5'h06;
  localparam logic [4:0] OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07;
  localparam logic [4:0] OP_CONJUNCTION = 5'h08;
  localparam logic [4:0] OP_CONJUNCTION_CONSTANT = 5'h09;
  localparam logic [4:0] OP_DISJUNCTION = 5'h0a;
  localparam logic [4:0] OP_DISJUNCTION_CONSTANT = 5'h0b;
  localparam logic [4:0] OP_EXCLUSIVE_DISJUNCTION = 5'h0c;
  localparam logic [4:0] OP_MASK_BITS_SET = 5'h0d;
  localparam logic [4:0] OP_MASK_BITS_CLEAR = 5'h0e;
  localparam logic [4:0] OP_IO_BIT_SET = 5'h10;
  localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h11;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR
  } aao_fn_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_LO, ST_HI
  } aao_state_t;

  // status flags, bit 0 is carry
  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } aao_flags_t;

  // command word: op in [4:0], bit index in [7:5], i/o address in [15:8]
  typedef struct packed {
    logic [7:0] io_addr;
    logic [2:0] bit_idx;
    logic [4:0] op;
  } aao_cmd_t;

  localparam aao_flags_t FLAGS_ARITH = '{h:1'b1, s:1'b0, v:1'b1, n:1'b1,
                                         z:1'b1, c:1'b1};
  localparam aao_flags_t FLAGS_WORD = '{h:1'b0, s:1'b1, v:1'b1, n:1'b1,
                                        z:1'b1, c:1'b1};
  localparam aao_flags_t FLAGS_LOGIC = '{h:1'b0, s:1'b0, v:1'b1, n:1'b1,
                                         z:1'b1, c:1'b0};
  localparam aao_flags_t FLAGS_NONE = '0;

endpackage

/* src/aao_alu8.sv */
/*
  aao_alu8: one 8-bit adder/subtractor/logic slice with carry, half
  carry and two's-complement overflow.
  assumes: purely combinational use; the caller registers the outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module aao_alu8
(
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire aao_pkg::aao_fn_t fn,
  // result
  output logic [7:0] r,
  output logic c,
  output logic h,
  output logic v
);

  logic [8:0] sum_w;
  logic [8:0] dif_w;

  assign sum_w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign dif_w = {1'b0, a} - {1'b0, b} - {8'h00, cin};

  always_comb
  begin
    r = a & b;
    c = 1'b0;
    h = 1'b0;
    v = 1'b0;
    unique case (fn)
      aao_pkg::FN_ADD:
      begin
        r = sum_w[7:0];
        c = sum_w[8];
        h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      end
      aao_pkg::FN_SUB:
      begin
        r = dif_w[7:0];
        c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      end
      aao_pkg::FN_AND: r = a & b;
      aao_pkg::FN_OR: r = a | b;
      aao_pkg::FN_XOR: r = a ^ b;
      default: r = a & b;
    endcase
  end

endmodule

`default_nettype wire

/* src/aao_datapath.sv */
/*
  aao_datapath: 8-bit arithmetic/logic datapath with register-pair word
  operations, status flags and a 32-entry i/o space reached by bit
  set/clear operations, all run from an apb slave.
  assumes: one clock, asynchronous active-low reset, an apb master that
  holds each request until pready, and flag events synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module aao_datapath
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware events into the clear-on-one flag register
  input wire logic [7:0] flag_event,
  // results toward the register file
  output logic [15:0] result,
  output aao_pkg::aao_flags_t flags,
  output logic done
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic aao_pkg::aao_fn_t op_fn(input logic [4:0] op);
    unique case (op)
      aao_pkg::OP_SUM, aao_pkg::OP_SUM_CARRY,
      aao_pkg::OP_WORD_IMMEDIATE_SUM: op_fn = aao_pkg::FN_ADD;
      aao_pkg::OP_CONJUNCTION, aao_pkg::OP_CONJUNCTION_CONSTANT,
      aao_pkg::OP_MASK_BITS_CLEAR: op_fn = aao_pkg::FN_AND;
      aao_pkg::OP_DISJUNCTION, aao_pkg::OP_DISJUNCTION_CONSTANT,
      aao_pkg::OP_MASK_BITS_SET: op_fn = aao_pkg::FN_OR;
      aao_pkg::OP_EXCLUSIVE_DISJUNCTION: op_fn = aao_pkg::FN_XOR;
      default: op_fn = aao_pkg::FN_SUB;
    endcase
  endfunction

  function automatic logic op_word(input logic [4:0] op);
    op_word = (op == aao_pkg::OP_WORD_IMMEDIATE_SUM) ||
              (op == aao_pkg::OP_WORD_IMMEDIATE_DIFFERENCE);
  endfunction

  function automatic logic op_io(input logic [4:0] op);
    op_io = (op == aao_pkg::OP_IO_BIT_SET) ||
            (op == aao_pkg::OP_IO_BIT_CLEAR);
  endfunction

  function automatic logic op_carry_in(input logic [4:0] op);
    op_carry_in = (op == aao_pkg::OP_SUM_CARRY) ||
                  (op == aao_pkg::OP_DIFFERENCE_WITH_BORROW) ||
                  (op == aao_pkg::OP_DIFFERENCE_CONSTANT_BORROW);
  endfunction

  // which flags an operation writes; the rest keep their value
  function automatic aao_pkg::aao_flags_t op_flags(input logic [4:0] op);
    if (op_io(op))
      op_flags = aao_pkg::FLAGS_NONE;
    else if (op_word(op))
      op_flags = aao_pkg::FLAGS_WORD;
    else if (op_fn(op) == aao_pkg::FN_ADD || op_fn(op) == aao_pkg::FN_SUB)
      op_flags = aao_pkg::FLAGS_ARITH;
    else
      op_flags = aao_pkg::FLAGS_LOGIC;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  aao_pkg::aao_state_t state_reg;
  aao_pkg::aao_cmd_t cmd_reg;
  logic [7:0] opa_reg;
  logic [7:0] opb_reg;
  logic [7:0] oph_reg;
  logic [7:0] wlo_reg;
  logic wc_reg;
  logic range_err_reg;
  aao_pkg::aao_flags_t sreg_reg;
  logic [15:0] res_reg;
  logic done_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] io_mem [aao_pkg::IO_N];

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic access;
  logic acc_done;
  logic idle;
  logic in_io;
  logic [4:0] io_sel;
  logic hit_cmd;
  logic hit_opa;
  logic hit_opb;
  logic hit_oph;
  logic hit_res;
  logic hit_sreg;
  logic hit_stat;
  logic mapped;
  logic wr_done;
  logic [31:0] rd_data;
  logic pready_next;

  assign access = psel & penable;
  assign acc_done = access & pready_reg;
  assign idle = (state_reg == aao_pkg::ST_IDLE);
  assign in_io = (paddr & aao_pkg::IO_WIN_MASK) == aao_pkg::IO_BASE;
  assign io_sel = paddr[6:2];
  assign hit_cmd = paddr == aao_pkg::ADDR_CMD;
  assign hit_opa = paddr == aao_pkg::ADDR_OPA;
  assign hit_opb = paddr == aao_pkg::ADDR_OPB;
  assign hit_oph = paddr == aao_pkg::ADDR_OPH;
  assign hit_res = paddr == aao_pkg::ADDR_RES;
  assign hit_sreg = paddr == aao_pkg::ADDR_SREG;
  assign hit_stat = paddr == aao_pkg::ADDR_STAT;
  assign mapped = (in_io & (paddr[1:0] == 2'b00)) | hit_cmd | hit_opa |
                  hit_opb | hit_oph | hit_res | hit_sreg | hit_stat;
  assign wr_done = acc_done & pwrite & mapped;

  // every transfer waits one cycle, and longer while an operation runs,
  // so software never sees a half-updated result or flag set
  assign pready_next = access & ~pready_reg & idle;

  assign rd_data =
    in_io ? {24'h000000, io_mem[io_sel]} :
    hit_cmd ? {16'h0000, cmd_reg} :
    hit_opa ? {24'h000000, opa_reg} :
    hit_opb ? {24'h000000, opb_reg} :
    hit_oph ? {24'h000000, oph_reg} :
    hit_res ? {16'h0000, res_reg} :
    hit_sreg ? {26'h0000000, sreg_reg} :
    hit_stat ? {30'h00000000, range_err_reg, ~idle} :
    32'h00000000;

  // ----------------------------------------------------------------------
  // arithmetic slice
  // ----------------------------------------------------------------------
  logic hi_phase;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  aao_pkg::aao_fn_t alu_fn;
  logic [7:0] alu_r;
  logic alu_c;
  logic alu_h;
  logic alu_v;

  assign hi_phase = (state_reg == aao_pkg::ST_HI);
  // second word cycle only propagates the low-byte carry into the pair
  assign alu_a = hi_phase ? oph_reg : opa_reg;
  assign alu_b = hi_phase ? aao_pkg::BYTE_ZERO :
                 (cmd_reg.op == aao_pkg::OP_MASK_BITS_CLEAR) ?
                 aao_pkg::BYTE_ONES - opb_reg : opb_reg;
  assign alu_cin = hi_phase ? wc_reg :
                   (op_carry_in(cmd_reg.op) & sreg_reg.c);
  assign alu_fn = op_fn(cmd_reg.op);

  aao_alu8 u_alu
  (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .fn(alu_fn),
    .r(alu_r),
    .c(alu_c),
    .h(alu_h),
    .v(alu_v)
  );

  // ----------------------------------------------------------------------
  // flag computation
  // ----------------------------------------------------------------------
  aao_pkg::aao_flags_t new_flags;
  aao_pkg::aao_flags_t upd_mask;
  logic fin_byte;
  logic fin_word;
  logic fin_io;
  logic [15:0] word_res;

  assign word_res = {alu_r, wlo_reg};
  assign new_flags.c = alu_c;
  assign new_flags.h = alu_h;
  assign new_flags.n = alu_r[7];
  assign new_flags.z = hi_phase ? (word_res == 16'h0000) :
                       (alu_r == aao_pkg::BYTE_ZERO);
  assign new_flags.v = alu_v;
  assign new_flags.s = alu_r[7] ^ alu_v;
  assign upd_mask = op_flags(cmd_reg.op);

  assign fin_io = (state_reg == aao_pkg::ST_LO) & op_io(cmd_reg.op);
  assign fin_byte = (state_reg == aao_pkg::ST_LO) & ~op_io(cmd_reg.op) &
                    ~op_word(cmd_reg.op);
  assign fin_word = hi_phase;

  // ----------------------------------------------------------------------
  // i/o read-modify-write
  // ----------------------------------------------------------------------
  logic io_ok;
  logic [7:0] io_old;
  logic [7:0] io_bit;
  logic [7:0] io_mod;
  logic io_we;
  logic [4:0] io_widx;
  logic [7:0] io_wval;

  assign io_ok = cmd_reg.io_addr <= aao_pkg::IO_TOP_ADDR;
  assign io_old = io_mem[cmd_reg.io_addr[4:0]];
  assign io_bit = 8'h01 << cmd_reg.bit_idx;
  // the whole byte goes back, so a set flag is written as one and clears
  assign io_mod = (cmd_reg.op == aao_pkg::OP_IO_BIT_SET) ?
                  (io_old | io_bit) : (io_old & ~io_bit);
  assign io_we = (fin_io & io_ok) | (wr_done & in_io);
  assign io_widx = fin_io ? cmd_reg.io_addr[4:0] : io_sel;
  assign io_wval = fin_io ? io_mod : pwdata[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < aao_pkg::IO_N; gi++)
    begin : g_io
      localparam logic [7:0] W1C = (gi == aao_pkg::IO_FLAG_IDX) ?
                                   aao_pkg::IO_FLAG_MASK : 8'h00;
      logic hit;
      logic [7:0] wr_val;
      logic [7:0] nxt;
      assign hit = io_we & (io_widx == 5'(gi));
      // flag bits clear on a one, keep on a zero; plain bits take data
      assign wr_val = (io_mem[gi] & W1C & ~io_wval) |
                      (io_wval & ~W1C);
      // an event in the clearing cycle still sets the flag
      assign nxt = (hit ? wr_val : io_mem[gi]) | (flag_event & W1C);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          io_mem[gi] <= 8'h00;
        else
          io_mem[gi] <= nxt;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  aao_pkg::aao_state_t state_next;
  aao_pkg::aao_flags_t sreg_next;
  logic [15:0] res_next;
  logic range_err_next;
  logic start;

  assign start = wr_done & hit_cmd;
  assign state_next =
    start ? aao_pkg::ST_LO :
    (state_reg == aao_pkg::ST_LO && op_word(cmd_reg.op)) ? aao_pkg::ST_HI :
    aao_pkg::ST_IDLE;

  assign sreg_next =
    (fin_byte | fin_word) ?
      ((new_flags & upd_mask) | (sreg_reg & ~upd_mask)) :
    (wr_done & hit_sreg) ? aao_pkg::aao_flags_t'(pwdata[5:0]) :
    sreg_reg;

  assign res_next =
    fin_byte ? {8'h00, alu_r} :
    fin_word ? word_res :
    (fin_io & io_ok) ? {8'h00, io_mod} :
    res_reg;

  // set wins over a clear written in the same cycle
  assign range_err_next = (fin_io & ~io_ok) |
    (range_err_reg & ~(wr_done & hit_stat & pwdata[aao_pkg::STAT_RANGE]));

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= aao_pkg::ST_IDLE;
      cmd_reg <= '0;
      opa_reg <= 8'h00;
      opb_reg <= 8'h00;
      oph_reg <= 8'h00;
      sreg_reg <= '0;
      res_reg <= 16'h0000;
      range_err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sreg_reg <= sreg_next;
      res_reg <= res_next;
      range_err_reg <= range_err_next;
      if (start)
        cmd_reg <= aao_pkg::aao_cmd_t'(pwdata[15:0]);
      if (wr_done & hit_opa)
        opa_reg <= pwdata[7:0];
      if (wr_done & hit_opb)
        opb_reg <= pwdata[7:0];
      if (wr_done & hit_oph)
        oph_reg <= pwdata[7:0];
    end
  end

  // low byte of a word operation waits here for the high cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wlo_reg <= 8'h00;
      wc_reg <= 1'b0;
    end
    else if (state_reg == aao_pkg::ST_LO)
    begin
      wlo_reg <= alu_r;
      wc_reg <= alu_c;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_reg <= 1'b0;
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      done_reg <= fin_byte | fin_word | fin_io;
      pready_reg <= pready_next;
      pslverr_reg <= pready_next & ~mapped;
      if (pready_next)
        prdata_reg <= rd_data;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign result = res_reg;
  assign flags = sreg_reg;
  assign done = done_reg;

endmodule

`default_nettype wire

/* verif/aao_datapath_asserts.sv */
/*
  aao_datapath_asserts: port-level checks of the datapath, bound below.
  assumes: one clock domain, reset asynchronous and active low.
*/
`timescale 1ns/1ps
`default_nettype none

module aao_datapath_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // datapath side
  input wire logic [7:0] flag_event,
  input wire logic [15:0] result,
  input wire aao_pkg::aao_flags_t flags,
  input wire logic done
);
  // ------------------------------------------------------------------
  // command tracking
  // ------------------------------------------------------------------
  logic [4:0] op_reg;
  logic [7:0] io_reg;
  logic [15:0] res_reg;
  wire cmd_acc = psel && penable && pready && pwrite
    && (paddr == aao_pkg::ADDR_CMD);
  wire in_word = (pwdata[4:0] == 5'h02) || (pwdata[4:0] == 5'h07);
  wire op_word = (op_reg == 5'h02) || (op_reg == 5'h07);
  wire op_logic = (op_reg >= 5'h08) && (op_reg <= 5'h0e);
  wire op_io = (op_reg == 5'h10) || (op_reg == 5'h11);
  wire op_arith = !op_word && !op_logic && !op_io;

  // result kept at command time, so a refused i/o op can be judged
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      op_reg <= 5'h00;
      io_reg <= 8'h00;
      res_reg <= 16'h0000;
    end
    else if (cmd_acc)
    begin
      op_reg <= pwdata[4:0];
      io_reg <= pwdata[15:8];
      res_reg <= result;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_byte_timing: assert property (cmd_acc && !in_word
    && pwdata[4:0] <= 5'h0e |-> !done ##1 !done ##1 done)
    else $error("byte op did not finish in one cycle");
  a_word_timing: assert property (cmd_acc && in_word
    |-> !done ##1 !done ##1 !done ##1 done)
    else $error("word op did not take two cycles");
  a_sign_rule: assert property (done && op_word
    |-> flags.s == (flags.n ^ flags.v))
    else $error("sign flag differs from n xor v");
  a_logic_flags: assert property (done && op_logic |-> !flags.v
    && flags.z == (result[7:0] == 8'h00) && flags.n == result[7])
    else $error("logic op flags wrong");
  a_arith_flags: assert property (done && op_arith
    |-> flags.z == (result == 16'h0000) && flags.n == result[7])
    else $error("arith op zero or negative flag wrong");
  a_io_range: assert property (done && op_io && io_reg > 8'h1f
    |-> result == res_reg)
    else $error("out of range i/o op changed the result");

  c_word: cover property (done && op_word);
  c_io_bad: cover property (done && op_io && io_reg > 8'h1f);
  c_err: cover property (pslverr);
endmodule

bind aao_datapath aao_datapath_asserts u_aao_datapath_asserts (.clk,
  .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .flag_event, .result, .flags, .done);

`default_nettype wire

/* verif/aao_host_model.sv */
/*
  aao_host_model: the decoder side; apb master transfers and flag events.
  assumes: the testbench calls xfer and pulse, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module aao_host_model
(
  // clock
  input wire logic clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // hardware flag events
  output logic [7:0] flag_event
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    flag_event = 8'h00;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic t);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    t = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    flag_event <= v;
    @(posedge clk);
    flag_event <= 8'h00;
  endtask
endmodule

`default_nettype wire

/* verif/tb_aao_datapath.sv */
/*
  tb_aao_datapath: self-checking bench for the datapath over apb.
  assumes: the host model drives every design input but the clock/reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_aao_datapath;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] flag_event;
  logic [15:0] result;
  aao_pkg::aao_flags_t flags;
  logic done;
  logic [31:0] rdata;
  logic rerr;
  int mismatches = 0;
  int num_checks = 0;

  aao_datapath u_aao_datapath (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag_event(flag_event), .result(result), .flags(flags), .done(done));

  aao_host_model u_aao_host_model (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag_event(flag_event));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    logic t;
    u_aao_host_model.xfer(w, a, d, rdata, rerr, t);
    if (t)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic run(input logic [15:0] cmd, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] hi, input logic [5:0] sd);
    int n;
    acc(1'b1, aao_pkg::ADDR_SREG, {26'h0, sd});
    acc(1'b1, aao_pkg::ADDR_OPA, {24'h0, a});
    acc(1'b1, aao_pkg::ADDR_OPB, {24'h0, b});
    acc(1'b1, aao_pkg::ADDR_OPH, {24'h0, hi});
    acc(1'b1, aao_pkg::ADDR_CMD, {16'h0, cmd});
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 20);
    if (done !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // expected {flags, result} of one op, worked from the operation table
  function automatic logic [21:0] model(input logic [4:0] op,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] hi,
    input aao_pkg::aao_flags_t f);
    logic [8:0] r9;
    logic [4:0] r5;
    logic [16:0] r17;
    logic [7:0] r;
    logic ci;
    aao_pkg::aao_flags_t g;
    g = f;
    ci = f.c;
    if (op == 5'h02 || op == 5'h07)
    begin
      r17 = (op == 5'h02) ? {1'b0, hi, a} + b : {1'b0, hi, a} - b;
      g.c = r17[16];
      g.z = (r17[15:0] == 16'h0);
      g.n = r17[15];
      g.v = (op == 5'h02) ? (!hi[7] && r17[15]) : (hi[7] && !r17[15]);
      g.s = g.n ^ g.v;
      return {g, r17[15:0]};
    end
    if (op >= 5'h08)
    begin
      r = (op <= 5'h09) ? a & b : (op == 5'h0c) ? a ^ b :
        (op == 5'h0e) ? a & (8'hff - b) : a | b;
      g.z = (r == 8'h00);
      g.n = r[7];
      g.v = 1'b0;
      return {g, 8'h00, r};
    end
    if (op != 5'h01 && op != 5'h05 && op != 5'h06)
      ci = 1'b0;
    if (op <= 5'h01)
    begin
      r9 = a + b + ci;
      r5 = a[3:0] + b[3:0] + ci;
      g.v = (a[7] == b[7]) && (r9[7] != a[7]);
    end
    else
    begin
      r9 = a - b - ci;
      r5 = a[3:0] - b[3:0] - ci;
      g.v = (a[7] != b[7]) && (r9[7] != a[7]);
    end
    g.c = r9[8];
    g.h = r5[4];
    g.z = (r9[7:0] == 8'h00);
    g.n = r9[7];
    return {g, 8'h00, r9[7:0]};
  endfunction

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [21:0] ex;
    logic [4:0] op;
    logic v;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, aao_pkg::ADDR_SREG, 32'h0);
    check(rdata, 32'h0);
    acc(1'b0, aao_pkg::ADDR_STAT, 32'h0);
    check(rdata, 32'h0);
    // every arithmetic and logic op, once with all flags set and once with none
    for (int i = 0; i < 30; i++)
    begin
      op = 5'(i % 15);
      v = (i >= 15);
      ex = v ? model(op, 8'h00, 8'h01, 8'h00, 6'h00) :
        model(op, 8'h8f, 8'h71, 8'h7f, 6'h3f);
      run({11'h0, op}, v ? 8'h00 : 8'h8f, v ? 8'h01 : 8'h71,
        v ? 8'h00 : 8'h7f, v ? 6'h00 : 6'h3f);
      check({16'h0, result}, {16'h0, ex[15:0]});
      check({26'h0, flags}, {26'h0, ex[21:16]});
      acc(1'b0, aao_pkg::ADDR_SREG, 32'h0);
      check(rdata, {26'h0, ex[21:16]});
    end
    u_aao_host_model.pulse(8'hff);
    acc(1'b1, 8'hac, 32'h20);
    acc(1'b0, 8'hac, 32'h0);
    check(rdata, 32'hc0);
    run({8'h0b, 3'd0, aao_pkg::OP_IO_BIT_SET}, 8'h00, 8'h00, 8'h00, 6'h00);
    check({16'h0, result}, 32'hc1);
    check({26'h0, flags}, 32'h0);
    acc(1'b0, 8'hac, 32'h0);
    check(rdata, 32'h01);
    acc(1'b1, 8'hfc, 32'h5a);
    run({8'h1f, 3'd1, aao_pkg::OP_IO_BIT_CLEAR}, 8'h00, 8'h00, 8'h00, 6'h00);
    acc(1'b0, 8'hfc, 32'h0);
    check(rdata, 32'h58);
    run({8'h20, 3'd0, aao_pkg::OP_IO_BIT_SET}, 8'h00, 8'h00, 8'h00, 6'h00);
    check({16'h0, result}, 32'h58);
    acc(1'b0, aao_pkg::ADDR_STAT, 32'h0);
    check(rdata, 32'h2);
    acc(1'b1, aao_pkg::ADDR_STAT, 32'h2);
    acc(1'b0, aao_pkg::ADDR_STAT, 32'h0);
    check(rdata, 32'h0);
    acc(1'b0, 8'h40, 32'h0);
    check({31'h0, rerr}, 32'h1);
    check(rdata, 32'h0);
    acc(1'b1, aao_pkg::ADDR_RES, 32'h1234);
    acc(1'b0, aao_pkg::ADDR_RES, 32'h0);
    check(rdata, 32'h58);
    report_and_stop();
  end
endmodule

`default_nettype wire
